// ### gpx_defines.svh
`ifndef GPX_DEFINES_SVH
`define GPX_DEFINES_SVH

// ****************************************
// Command bytes selecting each register
// ****************************************
`define GPX_CMD_IN0 8'h00
`define GPX_CMD_IN1 8'h01
`define GPX_CMD_OUT0 8'h02
`define GPX_CMD_OUT1 8'h03
`define GPX_CMD_POL0 8'h04
`define GPX_CMD_POL1 8'h05
`define GPX_CMD_DIR0 8'h06
`define GPX_CMD_DIR1 8'h07
`define GPX_CMD_DRV0A 8'h08
`define GPX_CMD_DRV0B 8'h09
`define GPX_CMD_DRV1A 8'h0a
`define GPX_CMD_DRV1B 8'h0b
`define GPX_CMD_LAT0 8'h0c
`define GPX_CMD_LAT1 8'h0d
`define GPX_CMD_PEN0 8'h0e
`define GPX_CMD_PEN1 8'h0f
`define GPX_CMD_PSEL0 8'h10
`define GPX_CMD_PSEL1 8'h11
`define GPX_CMD_MASK0 8'h12
`define GPX_CMD_MASK1 8'h13
`define GPX_CMD_STAT0 8'h14
`define GPX_CMD_STAT1 8'h15
`define GPX_CMD_OCFG 8'h16

// ****************************************
// Reset values
// ****************************************
`define GPX_DIR_RST 16'hffff
`define GPX_OUT_RST 16'hffff
`define GPX_POL_RST 16'h0000
`define GPX_DRV_RST 32'hffff_ffff
`define GPX_LAT_RST 16'h0000
`define GPX_PEN_RST 16'h0000
`define GPX_PSEL_RST 16'hffff
`define GPX_MASK_RST 16'hffff
`define GPX_OCFG_RST 2'h0
`define GPX_BYTE_ZERO 8'h00

// ****************************************
// Slave addresses, arbitrary values
// ****************************************
`define GPX_ADDR_LOW 7'h20
`define GPX_ADDR_HIGH 7'h21

`endif

// ### gpx_pkg.sv
`default_nettype none

package gpx_pkg;

  // Settings that steer one bank of eight pins
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] out;
    logic od;
    logic [15:0] drv;
    logic [7:0] pull_en;
    logic [7:0] pull_sel;
  } gpx_bank_cfg_t;

  // Registered pad controls of one bank
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [15:0] drv;
    logic [7:0] pull_en;
    logic [7:0] pull_up;
  } gpx_bank_pad_t;

  // Register port state
  typedef enum logic [0:0] {
    GPX_BUS_IDLE,
    GPX_BUS_RESP
  } gpx_bus_state_t;

endpackage

`default_nettype wire

// ### gpx_pad_bank.sv
`include "gpx_defines.svh"
`default_nettype none

module gpx_pad_bank (
  input wire logic clk_i, // System clock
  input wire logic reset_i, // Async reset, active high
  input wire gpx_pkg::gpx_bank_cfg_t cfg_i, // Bank settings
  output var gpx_pkg::gpx_bank_pad_t pad_o // Registered pad controls
);

  gpx_pkg::gpx_bank_pad_t next_pad;

  // ****************************************
  // Pad control decode
  // ****************************************
  always_comb begin
    next_pad.o = cfg_i.od ? 8'h00 : cfg_i.out;
    next_pad.oe = ~cfg_i.dir;
    if (cfg_i.od) begin
      next_pad.oe = ~cfg_i.dir & ~cfg_i.out;
    end
    next_pad.drv = cfg_i.drv;
    next_pad.pull_en = cfg_i.pull_en;
    next_pad.pull_up = cfg_i.pull_en & cfg_i.pull_sel;
  end

  // Register so no decode glitch reaches the pins
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pad_o <= '0;
    end else begin
      pad_o <= next_pad;
    end
  end

  pad_oe_dir_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    ##1 pad_o.oe == ($past(~cfg_i.dir) &
      ~($past({8{cfg_i.od}}) & $past(cfg_i.out))))
    else $error("pad enable disagrees with direction");

  pull_select_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    ##1 pad_o.pull_up == $past(cfg_i.pull_en & cfg_i.pull_sel))
    else $error("pull-up disagrees with pull settings");

endmodule

`default_nettype wire

// ### gpx_expander.sv
`include "gpx_defines.svh"
`default_nettype none

// Overview of operation
// - All sixteen pins start as inputs after reset.
// - Every interrupt mask bit starts set, so no alert at power-up.
// - Open-drain low alert when an unmasked input differs from register.
// - Latched pins hold a changed value until the input register is read.
// - Polarity bits invert the input register value as read.
// - Direction bit per pin chooses driven or floating.
// - Input and output values live in registers; outputs drive pins.
// - Two 8-bit registers each for direction, input, output, polarity.
// - Reset returns all registers to defaults and resets the port logic.
// - Each bank selects push-pull or open-drain outputs.
// - Each pin has one of four drive strengths.
// - Per-pin pull enable, with pull-up or pull-down select.
// - A set mask bit keeps that pin from raising the alert.
// - Read-only status register shows which pins raised the alert.
// - Strap level picks one of two slave addresses.
module gpx_expander (
  input wire logic clk_i, // System clock
  input wire logic reset_i, // Async reset, active high
  input wire logic [6:0] slv_addr_i, // Addressed slave
  input wire logic [7:0] cmd_i, // Command byte
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  input wire logic addr_strap_i, // Address strap level
  input wire logic [15:0] pad_i, // Pin levels
  output logic [15:0] pad_o, // Pin drive values
  output logic [15:0] pad_oe_o, // Pin drive enables
  output logic [31:0] drv_o, // Drive strength, two bits a pin
  output logic [15:0] pull_en_o, // Pull resistor enables
  output logic [15:0] pull_up_o, // Pull-up when set, else pull-down
  output logic alert_o, // Alert pin value, always low
  output logic alert_oe_o // Alert pin sinking
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [15:0] dir;
  logic [15:0] out;
  logic [15:0] pol;
  logic [31:0] drv;
  logic [15:0] latch;
  logic [15:0] pen;
  logic [15:0] psel;
  logic [15:0] mask;
  logic [1:0] ocfg;
  logic [15:0] in_reg;
  logic [15:0] ref_val;
  logic [15:0] status;
  logic [15:0] chg;
  logic [15:0] held;
  logic [6:0] sel_addr;
  logic strap_done;
  logic acc_ok;
  logic wr_ok;
  logic rd_ok;
  logic rd_in0;
  logic rd_in1;
  logic [7:0] next_rdata;
  gpx_pkg::gpx_bus_state_t bus_state;
  gpx_pkg::gpx_bank_cfg_t cfg0;
  gpx_pkg::gpx_bank_cfg_t cfg1;
  gpx_pkg::gpx_bank_pad_t pad0;
  gpx_pkg::gpx_bank_pad_t pad1;

  // Command byte match, used for write and input-read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] c);
    hit = (a == c);
  endfunction

  // ****************************************
  // Address strap and access qualify
  // ****************************************
  // Strap caught by a clock after release, never by the reset itself
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      strap_done <= 1'b0;
      sel_addr <= `GPX_ADDR_LOW;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      sel_addr <= addr_strap_i ? `GPX_ADDR_HIGH : `GPX_ADDR_LOW;
    end
  end

  assign acc_ok = strap_done && (slv_addr_i == sel_addr);
  assign wr_ok = wr_i && acc_ok;
  assign rd_ok = rd_i && acc_ok;
  assign rd_in0 = rd_ok && hit(cmd_i, `GPX_CMD_IN0);
  assign rd_in1 = rd_ok && hit(cmd_i, `GPX_CMD_IN1);

  // ****************************************
  // Configuration registers
  // ****************************************
  // reset restores defaults
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dir <= `GPX_DIR_RST;
      out <= `GPX_OUT_RST;
      pol <= `GPX_POL_RST;
      drv <= `GPX_DRV_RST;
      latch <= `GPX_LAT_RST;
      pen <= `GPX_PEN_RST;
      psel <= `GPX_PSEL_RST;
      mask <= `GPX_MASK_RST;
      ocfg <= `GPX_OCFG_RST;
    end else if (wr_ok) begin
      if (hit(cmd_i, `GPX_CMD_OUT0)) out[7:0] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_OUT1)) out[15:8] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_POL0)) pol[7:0] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_POL1)) pol[15:8] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_DIR0)) dir[7:0] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_DIR1)) dir[15:8] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_DRV0A)) drv[7:0] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_DRV0B)) drv[15:8] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_DRV1A)) drv[23:16] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_DRV1B)) drv[31:24] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_LAT0)) latch[7:0] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_LAT1)) latch[15:8] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_PEN0)) pen[7:0] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_PEN1)) pen[15:8] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_PSEL0)) psel[7:0] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_PSEL1)) psel[15:8] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_MASK0)) mask[7:0] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_MASK1)) mask[15:8] <= wdata_i;
      if (hit(cmd_i, `GPX_CMD_OCFG)) ocfg <= wdata_i[1:0];
    end
  end

  // ****************************************
  // Input capture and latching
  // ****************************************
  // A latched pin freezes once it differs from the last value read
  assign held = latch & (in_reg ^ ref_val);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_reg <= 16'h0000;
    end else begin
      in_reg <= (held & in_reg) | (~held & pad_i);
    end
  end

  // Reading a bank makes its input register value, before polarity, the new reference
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_val <= 16'h0000;
    end else begin
      if (rd_in0) ref_val[7:0] <= in_reg[7:0];
      if (rd_in1) ref_val[15:8] <= in_reg[15:8];
    end
  end

  // ****************************************
  // Change detect and alert
  // ****************************************
  // Not sticky: a pin that returns to its reference drops its bit
  assign chg = in_reg ^ ref_val;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      status <= 16'h0000;
    end else begin
      status <= chg & ~mask;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      alert_oe_o <= 1'b0;
      alert_o <= 1'b0;
    end else begin
      alert_oe_o <= |(chg & ~mask);
      alert_o <= 1'b0;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    case (cmd_i)
      `GPX_CMD_IN0: next_rdata = in_reg[7:0] ^ pol[7:0];
      `GPX_CMD_IN1: next_rdata = in_reg[15:8] ^ pol[15:8];
      `GPX_CMD_OUT0: next_rdata = out[7:0];
      `GPX_CMD_OUT1: next_rdata = out[15:8];
      `GPX_CMD_POL0: next_rdata = pol[7:0];
      `GPX_CMD_POL1: next_rdata = pol[15:8];
      `GPX_CMD_DIR0: next_rdata = dir[7:0];
      `GPX_CMD_DIR1: next_rdata = dir[15:8];
      `GPX_CMD_DRV0A: next_rdata = drv[7:0];
      `GPX_CMD_DRV0B: next_rdata = drv[15:8];
      `GPX_CMD_DRV1A: next_rdata = drv[23:16];
      `GPX_CMD_DRV1B: next_rdata = drv[31:24];
      `GPX_CMD_LAT0: next_rdata = latch[7:0];
      `GPX_CMD_LAT1: next_rdata = latch[15:8];
      `GPX_CMD_PEN0: next_rdata = pen[7:0];
      `GPX_CMD_PEN1: next_rdata = pen[15:8];
      `GPX_CMD_PSEL0: next_rdata = psel[7:0];
      `GPX_CMD_PSEL1: next_rdata = psel[15:8];
      `GPX_CMD_MASK0: next_rdata = mask[7:0];
      `GPX_CMD_MASK1: next_rdata = mask[15:8];
      `GPX_CMD_STAT0: next_rdata = status[7:0];
      `GPX_CMD_STAT1: next_rdata = status[15:8];
      `GPX_CMD_OCFG: next_rdata = {6'h00, ocfg};
      default: next_rdata = `GPX_BYTE_ZERO;
    endcase
  end

  // Read data stands one cycle, then returns to zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_state <= gpx_pkg::GPX_BUS_IDLE;
      rdata_o <= `GPX_BYTE_ZERO;
    end else begin
      case (bus_state)
        gpx_pkg::GPX_BUS_IDLE,
        gpx_pkg::GPX_BUS_RESP: begin
          bus_state <= rd_ok ? gpx_pkg::GPX_BUS_RESP :
                               gpx_pkg::GPX_BUS_IDLE;
          rdata_o <= rd_ok ? next_rdata : `GPX_BYTE_ZERO;
        end
        default: begin
          bus_state <= gpx_pkg::GPX_BUS_IDLE;
          rdata_o <= `GPX_BYTE_ZERO;
        end
      endcase
    end
  end

  // ****************************************
  // Pad banks
  // ****************************************
  always_comb begin
    cfg0 = {dir[7:0], out[7:0], ocfg[0], drv[15:0], pen[7:0], psel[7:0]};
    cfg1 = {dir[15:8], out[15:8], ocfg[1], drv[31:16], pen[15:8],
            psel[15:8]};
  end

  gpx_pad_bank u_bank0 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .cfg_i(cfg0),
    .pad_o(pad0)
  );

  gpx_pad_bank u_bank1 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .cfg_i(cfg1),
    .pad_o(pad1)
  );

  assign pad_o = {pad1.o, pad0.o};
  assign pad_oe_o = {pad1.oe, pad0.oe};
  assign drv_o = {pad1.drv, pad0.drv};
  assign pull_en_o = {pad1.pull_en, pad0.pull_en};
  assign pull_up_o = {pad1.pull_up, pad0.pull_up};

  // ****************************************
  // Checks
  // ****************************************
  // pins start input
  dir_default_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !strap_done |-> (dir == `GPX_DIR_RST) ##1 (pad_oe_o == 16'h0000))
    else $error("pins not inputs after reset");
  mask_default_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !strap_done |-> (mask == `GPX_MASK_RST) ##1 !alert_oe_o)
    else $error("interrupt mask not set after reset");
  alert_raise_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    ((chg & ~mask) != 16'h0000) |=> alert_oe_o && !alert_o)
    else $error("alert missing for unmasked change");
  latch_hold_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (held != 16'h0000) |=>
      ((in_reg ^ $past(in_reg)) & $past(held)) == 16'h0000)
    else $error("latched input changed before read");
  pol_read_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    rd_in0 |=> rdata_o == $past(in_reg[7:0] ^ pol[7:0]))
    else $error("input read not polarity corrected");
  out_drive_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (!ocfg[0] && dir[7:0] == 8'h00) [*2] |-> pad_o[7:0] == $past(out[7:0]))
    else $error("push-pull pins not driven from output register");
  mask_block_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    ((chg & ~mask) == 16'h0000) |=> !alert_oe_o && status == 16'h0000)
    else $error("alert raised by masked pin");
  status_src_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    ##1 status == $past(chg & ~mask) && alert_oe_o == |status)
    else $error("status disagrees with alert source");
  strap_pick_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $rose(strap_done) |-> sel_addr ==
      ($past(addr_strap_i) ? `GPX_ADDR_HIGH : `GPX_ADDR_LOW))
    else $error("slave address not taken from strap");
  read_clear_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    rd_in1 |=> ref_val[15:8] == $past(in_reg[15:8]))
    else $error("input read did not take new reference");

endmodule

`default_nettype wire

// ### gpx_pin_model.sv
`default_nettype none

module gpx_pin_model (
  input wire logic clk_i, // System clock
  input wire logic [15:0] drive_i, // Expander drive values
  input wire logic [15:0] drive_en_i, // Expander drive enables
  input wire logic [15:0] pull_en_i, // Pull resistor enables
  input wire logic [15:0] pull_up_i, // Pull direction
  input wire logic [15:0] ext_val_i, // Board source values
  input wire logic [15:0] ext_en_i, // Board source enables
  output logic [15:0] level_o // Resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] drift = 16'h0000;

  // ****************************************
  // Pin resolution
  // ****************************************
  // drive, board source, pull, float
  always_comb begin
    for (int n = 0; n < 16; n++) begin
      if (drive_en_i[n]) begin
        level_o[n] = drive_i[n];
      end else if (ext_en_i[n]) begin
        level_o[n] = ext_val_i[n];
      end else if (pull_en_i[n]) begin
        level_o[n] = pull_up_i[n];
      end else begin
        level_o[n] = drift[n];
      end
    end
  end

  // Undriven lines toggle so a stale level never passes for a real one
  always @(posedge clk_i) begin
    drift <= ~level_o;
  end

endmodule

`default_nettype wire

// ### tb.sv
`include "gpx_defines.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic reset_i = 1'b1;
  logic [6:0] slv = `GPX_ADDR_LOW;
  logic [7:0] cmd = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic strap = 1'b0;
  logic [15:0] ext_val = 16'h0000;
  logic [15:0] ext_en = 16'hff00;
  logic [15:0] lvl;
  logic [7:0] rdata;
  logic [15:0] pad;
  logic [15:0] pad_oe;
  logic [15:0] pull_en;
  logic [15:0] pull_up;
  logic [31:0] drv;
  logic alert;
  logic alert_oe;
  logic [7:0] exp_q[$];
  logic [7:0] rnd [0:17];
  logic [7:0] dflt [0:17] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
    8'hff, 8'hff, 8'hff};
  int error_cnt = 0;
  int n_compared = 0;

  gpx_expander dut (.clk_i(clk), .reset_i(reset_i), .slv_addr_i(slv),
    .cmd_i(cmd), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .addr_strap_i(strap), .pad_i(lvl), .pad_o(pad), .pad_oe_o(pad_oe),
    .drv_o(drv), .pull_en_o(pull_en), .pull_up_o(pull_up),
    .alert_o(alert), .alert_oe_o(alert_oe));

  gpx_pin_model pins (.clk_i(clk), .drive_i(pad), .drive_en_i(pad_oe),
    .pull_en_i(pull_en), .pull_up_i(pull_up), .ext_val_i(ext_val),
    .ext_en_i(ext_en), .level_o(lvl));

  initial begin
    forever #50 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One strobe cycle; for a read the data argument is the expected value
  task automatic acc(input logic w, input logic [7:0] c,
                     input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    cmd <= c;
    wdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wrt(input logic [7:0] c, input logic [7:0] d);
    acc(1'b1, c, d);
  endtask

  task automatic rdx(input logic [7:0] c, input logic [7:0] e);
    acc(1'b0, c, e);
  endtask

  // Waits past the two-edge latency of pad outputs and alert
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic pins_to(input logic [15:0] v);
    @(posedge clk);
    ext_val <= v;
    settle();
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk);
    reset_i <= 1'b1;
    strap <= s;
    slv <= s ? `GPX_ADDR_HIGH : `GPX_ADDR_LOW;
    repeat (4) @(posedge clk);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic chk_dflt;
    for (int i = 0; i < 18; i++) rdx(8'(i + 2), dflt[i]);
    rdx(`GPX_CMD_OCFG, 8'h00);
    settle();
    chk("pad_oe", 32'h0000_0000, {16'h0000, pad_oe});
    chk("alert_oe", 32'h0000_0000, {31'h0, alert_oe});
    chk("drv", 32'hffff_ffff, drv);
    chk("pull_en", 32'h0000_0000, {16'h0000, pull_en});
  endtask

  task automatic summarize;
    repeat (3) @(posedge clk);
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Read data watcher
  // ****************************************
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) begin
      if (exp_q.size() == 0) chk("rdata note", 32'h1, 32'h0);
      else chk("rdata", {24'h0, exp_q.pop_front()}, {24'h0, rdata});
    end
    rd_d <= rd;
  end

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hf4c8));
    do_reset(1'b0);
    chk_dflt();
    for (int i = 0; i < 18; i++) begin
      rnd[i] = 8'($urandom());
      wrt(8'(i + 2), rnd[i]);
    end
    for (int i = 0; i < 18; i++) rdx(8'(i + 2), rnd[i]);
    wrt(`GPX_CMD_OCFG, 8'hff);
    rdx(`GPX_CMD_OCFG, 8'h03);
    wrt(`GPX_CMD_MASK0, 8'hff);
    wrt(`GPX_CMD_STAT0, 8'hff);
    rdx(`GPX_CMD_STAT0, 8'h00);
    rdx(8'h17, 8'h00);
    slv <= `GPX_ADDR_HIGH;
    rdx(`GPX_CMD_DIR0, 8'h00);
    do_reset(1'b1);
    chk_dflt();
    slv <= `GPX_ADDR_LOW;
    wrt(`GPX_CMD_DIR1, 8'h00);
    slv <= `GPX_ADDR_HIGH;
    rdx(`GPX_CMD_DIR1, 8'hff);
    // Bank 0 becomes outputs, bank 1 stays input
    wrt(`GPX_CMD_DIR0, 8'h00);
    wrt(`GPX_CMD_OUT0, 8'ha5);
    settle();
    chk("pad", 32'h0000_00a5, {24'h0, pad[7:0]});
    chk("pad_oe", 32'h0000_00ff, {16'h0, pad_oe});
    rdx(`GPX_CMD_IN0, 8'ha5);
    wrt(`GPX_CMD_OCFG, 8'h01);
    wrt(`GPX_CMD_DRV0A, 8'h1b);
    wrt(`GPX_CMD_PEN1, 8'hf0);
    wrt(`GPX_CMD_PSEL1, 8'hcc);
    settle();
    chk("pad", 32'h0000_0000, {24'h0, pad[7:0]});
    chk("pad_oe", 32'h0000_005a, {16'h0, pad_oe});
    chk("drv", 32'hffff_ff1b, drv);
    chk("pull_en", 32'h0000_f000, {16'h0, pull_en});
    chk("pull_up", 32'h0000_c000, {16'h0, pull_up});
    // Inputs and polarity on bank 1
    pins_to(16'h3c00);
    rdx(`GPX_CMD_IN1, 8'h3c);
    wrt(`GPX_CMD_POL1, 8'hff);
    rdx(`GPX_CMD_IN1, 8'hc3);
    wrt(`GPX_CMD_POL1, 8'h00);
    // Only pin 8 may raise the alert
    wrt(`GPX_CMD_MASK1, 8'hfe);
    pins_to(16'h3d00);
    chk("alert_oe", 32'h1, {31'h0, alert_oe});
    chk("alert", 32'h0, {31'h0, alert});
    rdx(`GPX_CMD_STAT1, 8'h01);
    pins_to(16'h3c00);
    chk("alert_oe", 32'h0, {31'h0, alert_oe});
    pins_to(16'h3e00);
    chk("alert_oe", 32'h0, {31'h0, alert_oe});
    pins_to(16'h3f00);
    chk("alert_oe", 32'h1, {31'h0, alert_oe});
    rdx(`GPX_CMD_IN1, 8'h3f);
    settle();
    chk("alert_oe", 32'h0, {31'h0, alert_oe});
    // A latched pin keeps a short pulse until the bank is read
    wrt(`GPX_CMD_LAT1, 8'h01);
    pins_to(16'h3e00);
    pins_to(16'h3f00);
    chk("alert_oe", 32'h1, {31'h0, alert_oe});
    rdx(`GPX_CMD_IN1, 8'h3e);
    settle();
    rdx(`GPX_CMD_IN1, 8'h3f);
    settle();
    chk("alert_oe", 32'h0, {31'h0, alert_oe});
    summarize();
  end

endmodule

`default_nettype wire
